// *** design/plc_pin_if.sv ***
// Purpose: device-side digital pin logic of a half-duplex power-line modem
// Assumes: all inputs except rstn_i synchronous to clock_i; detector levels from analog side
// Notes: one clock domain; access clocks are divided from clock_i
`timescale 1ns/1ps
module plc_pin_if
  import plc_pin_pkg::*;
#(
  parameter int unsigned WDOG_CYC = (WDOG_MS * (CLK_HZ / 1000)),
  parameter int unsigned POR_CYC = RESET_PULSE_CYC
)
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic enable_i,
  input wire logic [plc_pin_pkg::ADDR_W-1:0] addr_i,
  input wire logic [plc_pin_pkg::DATA_W-1:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [plc_pin_pkg::DATA_W-1:0] rdata_o,
  output logic irq_o,
  input wire logic direction_select_i,
  input wire logic access_select_i,
  input wire logic tx_data_i,
  input wire logic watchdog_kick_i,
  input wire logic carrier_seen_i,
  input wire logic band_signal_i,
  input wire logic tx_timeout_event_i,
  input wire logic checksum_bad_i,
  input wire logic supply_above_high_i,
  input wire logic supply_below_low_i,
  output logic carrier_detect_n_o,
  output logic band_occupied_o,
  output logic tx_timeout_flag_o,
  output logic checksum_fault_o,
  output logic supply_good_o,
  output logic reset_out_o,
  output logic serial_access_clock_o,
  output logic master_clock_o,
  output logic tx_line_data_o,
  output logic register_mode_o
);
  import plc_pin_pkg::*;

  localparam int unsigned WD_W = $clog2(WDOG_CYC + 1);
  localparam int unsigned POR_W = $clog2(POR_CYC + 1);

  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic [EV_W-1:0] events;
  logic [CTRL_DIV_W-1:0] mclk_div;
  logic [CTRL_DIV_W-1:0] sclk_div;
  logic [CTRL_DIV_W-1:0] mclk_cnt;
  logic [CTRL_DIV_W-1:0] sclk_cnt;
  logic [WD_W-1:0] wd_cnt;
  logic [POR_W-1:0] rst_cnt;
  logic kick_prev;
  logic kick_fall;
  logic wd_expire;
  logic to_clear;
  logic carrier_q;
  logic band_q;
  logic checksum_q;
  logic supply_q;
  logic in_reset;

  function automatic logic is_read(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    is_read = read_i && (a == ofs);
  endfunction

  // ===========================================================
  // watchdog
  // ===========================================================
  assign kick_fall = kick_prev && !watchdog_kick_i;
  assign wd_expire = (wd_cnt == WD_W'(WDOG_CYC - 1)) && !kick_fall;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      kick_prev <= 1'b1;
    else if (enable_i)
      kick_prev <= watchdog_kick_i;
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wd_cnt <= '0;
    else if (enable_i)
    begin
      if (kick_fall || wd_expire || in_reset)
        wd_cnt <= '0;
      else
        wd_cnt <= wd_cnt + WD_W'(1);
    end
  end

  // ===========================================================
  // reset output: stretched pulse after power-on or expiry
  // ===========================================================
  assign in_reset = (rst_cnt != '0);

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_cnt <= POR_W'(POR_CYC);
    else if (enable_i)
    begin
      if (wd_expire)
        rst_cnt <= POR_W'(POR_CYC);
      else if (in_reset)
        rst_cnt <= rst_cnt - POR_W'(1);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      reset_out_o <= 1'b1;
    else if (enable_i)
      reset_out_o <= in_reset || wd_expire;
  end

  // ===========================================================
  // status pins
  // ===========================================================
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      carrier_q <= 1'b0;
      band_q <= 1'b0;
      checksum_q <= 1'b0;
    end
    else if (enable_i)
    begin
      carrier_q <= carrier_seen_i;
      band_q <= band_signal_i;
      checksum_q <= checksum_bad_i;
    end
  end

  assign carrier_detect_n_o = !carrier_q;
  assign band_occupied_o = band_q;
  assign checksum_fault_o = checksum_q;

  // hysteresis: hold between thresholds so the pin does not chatter
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      supply_q <= 1'b0;
    else if (enable_i)
    begin
      if (supply_above_high_i)
        supply_q <= 1'b1;
      else if (supply_below_low_i)
        supply_q <= 1'b0;
    end
  end

  assign supply_good_o = supply_q;

  // sticky until software clears it via the control register
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tx_timeout_flag_o <= 1'b0;
    else if (enable_i)
    begin
      if (tx_timeout_event_i)
        tx_timeout_flag_o <= 1'b1;
      else if (to_clear)
        tx_timeout_flag_o <= 1'b0;
    end
  end

  // ===========================================================
  // host selectors
  // ===========================================================
  // data is passed only in a transmit session
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_line_data_o <= 1'b0;
      register_mode_o <= 1'b0;
    end
    else if (enable_i)
    begin
      tx_line_data_o <= !direction_select_i && tx_data_i;
      register_mode_o <= access_select_i;
    end
  end

  // ===========================================================
  // clock outputs
  // ===========================================================
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mclk_cnt <= '0;
      master_clock_o <= 1'b0;
    end
    else if (enable_i)
    begin
      if (mclk_cnt >= mclk_div)
      begin
        mclk_cnt <= '0;
        master_clock_o <= !master_clock_o;
      end
      else
        mclk_cnt <= mclk_cnt + CTRL_DIV_W'(1);
    end
  end

  // one divider serves both access modes; the selector picks the consumer
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sclk_cnt <= '0;
      serial_access_clock_o <= 1'b0;
    end
    else if (enable_i)
    begin
      if (in_reset)
      begin
        sclk_cnt <= '0;
        serial_access_clock_o <= 1'b0;
      end
      else if (sclk_cnt >= sclk_div)
      begin
        sclk_cnt <= '0;
        serial_access_clock_o <= !serial_access_clock_o;
      end
      else
        sclk_cnt <= sclk_cnt + CTRL_DIV_W'(1);
    end
  end

  // ===========================================================
  // registers and interrupt
  // ===========================================================
  assign events[EV_CARRIER] = carrier_seen_i && !carrier_q;
  assign events[EV_BAND] = band_signal_i && !band_q;
  assign events[EV_TIMEOUT] = tx_timeout_event_i;
  assign events[EV_CHECKSUM] = checksum_bad_i && !checksum_q;
  assign events[EV_SUPPLY] = supply_below_low_i && supply_q;
  assign events[EV_WDOG] = wd_expire;
  assign to_clear = write_i && (addr_i == OFS_CTRL) && wdata_i[CTRL_TO_CLR];

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      status <= '0;
    else if (enable_i)
    begin
      // a new event wins over the clear-on-read
      if (is_read(addr_i, OFS_STATUS))
        status <= events;
      else
        status <= status | events;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mask <= '0;
      mclk_div <= MCLK_DIV_RST;
      sclk_div <= SCLK_DIV_RST;
    end
    else if (enable_i && write_i)
    begin
      if (addr_i == OFS_MASK)
        mask <= wdata_i[EV_W-1:0];
      if (addr_i == OFS_CTRL)
      begin
        mclk_div <= wdata_i[CTRL_MCLK_DIV_LSB +: CTRL_DIV_W];
        sclk_div <= wdata_i[CTRL_SCLK_DIV_LSB +: CTRL_DIV_W];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      irq_o <= 1'b0;
    else if (enable_i)
      irq_o <= |(status & mask);
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= '0;
    else if (enable_i)
    begin
      rdata_o <= READ_UNMAPPED;
      if (read_i)
      begin
        case (addr_i)
          OFS_STATUS: rdata_o <= DATA_W'(status);
          OFS_MASK: rdata_o <= DATA_W'(mask);
          OFS_CTRL:
            rdata_o <= DATA_W'({sclk_div, mclk_div});
          OFS_LEVEL:
            rdata_o <= DATA_W'({register_mode_o, tx_timeout_flag_o, supply_q,
                                checksum_q, band_q, carrier_q});
          OFS_WDCOUNT: rdata_o <= DATA_W'(wd_cnt);
          default: rdata_o <= READ_UNMAPPED;
        endcase
      end
    end
  end
endmodule

// *** design/plc_pin_pkg.sv ***
// Purpose: constants for the power-line modem host pin interface
// Assumes: one 40 MHz clock, register port as address/strobes/read data
// Notes: the analog front end reports its detector levels as plain inputs
// Operation
// - carrier detect output low while carrier seen
// - timeout flag high once transmit timeout occurred
// - serial access clock for mains or register
// - band occupied high while in-band signal present
// - reset output at power-on and watchdog expiry
// - watchdog counter cleared on kick falling edge
// - checksum fault high when stored contents corrupt
// - master clock derived from oscillator
package plc_pin_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  // register indices (word addresses on the plain port)
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_MASK = 4'h1;
  localparam logic [3:0] OFS_CTRL = 4'h2;
  localparam logic [3:0] OFS_LEVEL = 4'h3;
  localparam logic [3:0] OFS_WDCOUNT = 4'h4;
  // event bits in status and mask
  localparam int unsigned EV_CARRIER = 0;
  localparam int unsigned EV_BAND = 1;
  localparam int unsigned EV_TIMEOUT = 2;
  localparam int unsigned EV_CHECKSUM = 3;
  localparam int unsigned EV_SUPPLY = 4;
  localparam int unsigned EV_WDOG = 5;
  localparam int unsigned EV_W = 6;
  // control fields
  localparam int unsigned CTRL_MCLK_DIV_LSB = 0;
  localparam int unsigned CTRL_SCLK_DIV_LSB = 8;
  localparam int unsigned CTRL_DIV_W = 8;
  localparam int unsigned CTRL_TO_CLR = 16;
  localparam logic [7:0] MCLK_DIV_RST = 8'h01;
  localparam logic [7:0] SCLK_DIV_RST = 8'h13;
  // watchdog interval
  localparam int unsigned WDOG_MS = 1500;
  localparam int unsigned RESET_PULSE_US = 100;
  localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_US * (CLK_HZ / 1000000));
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h0000_0000;
endpackage

// *** dv/plc_host_model.sv ***
// Purpose: host controller driving the modem control pins
// Assumes: one clock shared with the modem logic
// Notes: kicks every 16 cycles, well inside the short watchdog span
`timescale 1ns/1ps
module plc_host_model
(
  input wire logic clock_i,
  input wire logic kick_on_i,
  input wire logic rx_i,
  input wire logic reg_i,
  output logic direction_select_o = 1'b1,
  output logic access_select_o = 1'b0,
  output logic watchdog_kick_o = 1'b1
);
  logic [3:0] tick = 4'h0;
  always @(posedge clock_i)
  begin
    tick <= tick + 4'h1;
    direction_select_o <= rx_i;
    access_select_o <= reg_i;
    // a stopped host leaves the pin pulled high, so no clearing edge
    watchdog_kick_o <= kick_on_i ? tick[3] : 1'b1;
  end
endmodule

// *** dv/plc_modem_host_pin_interface_bench.sv ***
// Purpose: self-checking bench for the modem pin logic
// Assumes: short watchdog and power-on counts set by parameter
// Notes: detector levels come from a fixed-seed xorshift
`timescale 1ns/1ps
module plc_modem_host_pin_interface_bench;
  import plc_pin_pkg::*;
  localparam int unsigned WD = 200;
  logic clock_i = 1'b0, rstn_i = 1'b0, enable_i = 1'b1, write_i = 1'b0, read_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0, rdata_o, seed = 32'h63b7b677, d;
  logic tx_data_i = 1'b0, carrier_seen_i = 1'b0, band_signal_i = 1'b0, checksum_bad_i = 1'b0;
  logic tx_timeout_event_i = 1'b0, supply_above_high_i = 1'b0, supply_below_low_i = 1'b0;
  logic kick_on = 1'b1, rx = 1'b1, rg = 1'b0, cp, bp, kp, sg, to, tl, rm, mc, sc;
  logic irq_o, direction_select_i, access_select_i, watchdog_kick_i, carrier_detect_n_o;
  logic band_occupied_o, tx_timeout_flag_o, checksum_fault_o, supply_good_o, reset_out_o;
  logic serial_access_clock_o, master_clock_o, tx_line_data_o, register_mode_o;
  int n_mismatch = 0, total_checks = 0, n, mt, st;
  initial forever #12.5 clock_i = ~clock_i;
  plc_pin_if #(.WDOG_CYC(WD), .POR_CYC(10)) plc_pin_if_i (.*);
  plc_host_model plc_host_model_i (.clock_i(clock_i), .kick_on_i(kick_on), .rx_i(rx),
    .reg_i(rg), .direction_select_o(direction_select_i), .access_select_o(access_select_i),
    .watchdog_kick_o(watchdog_kick_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // above wins when both comparators report
  function automatic logic sg_next(input logic g, input logic hi, input logic lo);
    return hi ? 1'b1 : (lo ? 1'b0 : g);
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clock_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #(25 * 5000);
    n_mismatch++;
    final_report();
  end
  initial
  begin
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    #1;
    chk("por_on", 1, reset_out_o);
    repeat (20) @(posedge clock_i);
    #1;
    chk("por_off", 0, reset_out_o);
    sg = 1'b0;
    to = 1'b0;
    mt = 0;
    st = 0;
    mc = master_clock_o;
    sc = serial_access_clock_o;
    for (int i = 0; i < 200; i++)
    begin
      @(posedge clock_i);
      seed = xs(seed);
      {carrier_seen_i, band_signal_i, checksum_bad_i, tx_data_i} <= seed[3:0];
      {supply_above_high_i, supply_below_low_i, rx, rg} <= seed[7:4];
      tx_timeout_event_i <= &seed[10:8];
      #1;
      if (i > 0)
      begin
        chk("carrier_n", !cp, carrier_detect_n_o);
        chk("band", bp, band_occupied_o);
        chk("checksum", kp, checksum_fault_o);
        chk("timeout", to, tx_timeout_flag_o);
        chk("supply", sg, supply_good_o);
        chk("tx_line", tl, tx_line_data_o);
        chk("reg_mode", rm, register_mode_o);
        chk("no_reset", 0, reset_out_o);
      end
      mt += (master_clock_o !== mc);
      st += (serial_access_clock_o !== sc);
      {mc, sc, cp, bp, kp} = {master_clock_o, serial_access_clock_o, carrier_seen_i,
        band_signal_i, checksum_bad_i};
      tl = tx_data_i && !direction_select_i;
      rm = access_select_i;
      sg = sg_next(sg, supply_above_high_i, supply_below_low_i);
      to = to | tx_timeout_event_i;
    end
    chk("mclk_rate", 1, mt >= 98 && mt <= 101);
    chk("sclk_rate", 1, st >= 9 && st <= 11);
    $display("test pins done");
    {carrier_seen_i, band_signal_i, tx_timeout_event_i} <= 3'h0;
    {supply_above_high_i, supply_below_low_i} <= 2'h0;
    rd(OFS_CTRL, d);
    chk("ctrl_rst", 32'h0000_1301, d);
    @(posedge clock_i);
    #1;
    chk("rdata_idle", 0, rdata_o);
    rd(4'hf, d);
    chk("unmapped", READ_UNMAPPED, d);
    wr(OFS_CTRL, 32'h0001_1301);
    @(posedge clock_i);
    #1;
    chk("to_clear", 0, tx_timeout_flag_o);
    rd(OFS_STATUS, d);
    wr(OFS_MASK, 32'h1 << EV_CARRIER);
    @(posedge clock_i);
    carrier_seen_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    chk("irq_set", 1, irq_o);
    rd(OFS_STATUS, d);
    chk("status", 32'h1 << EV_CARRIER, d);
    repeat (2) @(posedge clock_i);
    band_signal_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    chk("irq_masked", 0, irq_o);
    chk("band_on", 1, band_occupied_o);
    rd(OFS_LEVEL, d);
    chk("level", 32'h3, {30'h0, d[1:0]});
    // clock enable low must freeze the pin copies
    @(posedge clock_i);
    enable_i <= 1'b0;
    carrier_seen_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    chk("frozen", 0, carrier_detect_n_o);
    @(posedge clock_i);
    enable_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    chk("thawed", 1, carrier_detect_n_o);
    $display("test regs done");
    @(posedge clock_i);
    kick_on <= 1'b0;
    n = 0;
    while (reset_out_o !== 1'b1 && n < 400)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk("wd_fire", 1, reset_out_o);
    chk("wd_late", 1, n > WD - 30);
    @(posedge clock_i);
    kick_on <= 1'b1;
    repeat (20) @(posedge clock_i);
    rd(OFS_STATUS, d);
    chk("wd_status", 1, d[EV_WDOG]);
    $display("test watchdog done");
    final_report();
  end
endmodule

// *** dv/plc_pin_if_checker.sv ***
// Purpose: port assertions for the modem pin logic
// Assumes: one clock, asynchronous active-low reset
// Notes: pin outputs lag their causes by one cycle
`timescale 1ns/1ps
module plc_pin_if_checker
#(
  parameter int unsigned WDOG_CYC = 200,
  parameter int unsigned POR_CYC = 10
)
(
  input wire logic clock_i, rstn_i, enable_i, direction_select_i, access_select_i,
  input wire logic tx_data_i, watchdog_kick_i, carrier_seen_i, band_signal_i,
  input wire logic tx_timeout_event_i, checksum_bad_i, supply_above_high_i,
  input wire logic supply_below_low_i, carrier_detect_n_o, band_occupied_o,
  input wire logic tx_timeout_flag_o, checksum_fault_o, supply_good_o, reset_out_o,
  input wire logic serial_access_clock_o, tx_line_data_o, register_mode_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // ==========
  // cycles since the last clearing edge
  logic [31:0] idle;
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      idle <= '0;
    else if (reset_out_o || ($past(watchdog_kick_i) && !watchdog_kick_i))
      idle <= '0;
    else if (enable_i)
      idle <= idle + 32'h1;
  end
  // ==========
  // assertions
  property p_carrier; $past(rstn_i) && $past(enable_i) |-> carrier_detect_n_o == !$past(carrier_seen_i); endproperty
  a_carrier: assert property (p_carrier) else $error("carrier detect wrong");
  property p_band; enable_i |=> band_occupied_o == $past(band_signal_i); endproperty
  a_band: assert property (p_band) else $error("band occupied wrong");
  property p_csum; enable_i && checksum_bad_i |=> checksum_fault_o; endproperty
  a_csum: assert property (p_csum) else $error("checksum fault missing");
  property p_tx_timeout_flag; enable_i && tx_timeout_event_i |=> tx_timeout_flag_o [*2]; endproperty
  a_tx_timeout_flag: assert property (p_tx_timeout_flag) else $error("timeout flag missing");
  property p_supply; enable_i && supply_below_low_i && !supply_above_high_i |=> !supply_good_o; endproperty
  a_supply: assert property (p_supply) else $error("supply good stuck");
  property p_wdog; $rose(reset_out_o) |-> idle >= WDOG_CYC - 4; endproperty
  a_wdog: assert property (p_wdog) else $error("early watchdog reset");
  property p_sclk; reset_out_o && $past(reset_out_o) |-> !serial_access_clock_o; endproperty
  a_sclk: assert property (p_sclk) else $error("access clock runs in reset");
  property p_txl; enable_i |=> tx_line_data_o == ($past(tx_data_i) && !$past(direction_select_i)); endproperty
  a_txl: assert property (p_txl) else $error("tx line wrong");
  property p_reg; enable_i |=> register_mode_o == $past(access_select_i); endproperty
  a_reg: assert property (p_reg) else $error("access mode wrong");
endmodule
bind plc_pin_if plc_pin_if_checker #(.WDOG_CYC(WDOG_CYC), .POR_CYC(POR_CYC)) chk_i (.*);
